// ---- hdl/dcbm_cfg.svh ----
// Purpose: offsets, field positions and reset values of the input block
// Assumes: 32-bit APB, word-aligned registers
// Notes: definitions only
`ifndef DCBM_CFG_SVH
`define DCBM_CFG_SVH

// -----------------------------------------------------------------
// register offsets
// -----------------------------------------------------------------
`define DCBM_ADDR_W 12
`define DCBM_CTRL_OFS 12'h000
`define DCBM_STAT_OFS 12'h004
`define DCBM_SYNC_OFS 12'h008

// -----------------------------------------------------------------
// control fields
// -----------------------------------------------------------------
`define DCBM_CTRL_W 9
`define DCBM_CTRL_RST 9'h000
`define DCBM_SYNCSEL_BIT 0
`define DCBM_CLKOFF_BIT 1
`define DCBM_DUALEN_BIT 2
`define DCBM_BUS_LO 3
`define DCBM_FLAG_BIT 5
`define DCBM_INTERP_LO 6
`define DCBM_EN_BIT 8

// -----------------------------------------------------------------
// status and sync fields
// -----------------------------------------------------------------
`define DCBM_MODE_LO 0
`define DCBM_LEVEL_LO 4
`define DCBM_OVF_BIT 8
`define DCBM_UNF_BIT 9
`define DCBM_SYNC_GO_BIT 0

// -----------------------------------------------------------------
// data path
// -----------------------------------------------------------------
`define DCBM_SAMPLE_W 16
`define DCBM_FIFO_DEPTH 8
`define DCBM_FIFO_AW 3
`define DCBM_PER_W 5
`define DCBM_PER_MIN 5'h02

`endif

// ---- hdl/dcbm_pkg.sv ----
// Purpose: types shared by the input block
// Assumes: nothing
// Notes: one-hot state codes
package dcbm_pkg;

  typedef enum logic [3:0] {
    DCBM_MODE_OFF  = 4'h1,
    DCBM_MODE_SYNC = 4'h2,
    DCBM_MODE_DUAL = 4'h4,
    DCBM_MODE_EXT  = 4'h8
  } dcbm_mode_t;

  typedef enum logic [1:0] {
    DCBM_BUS_DUAL  = 2'h0,
    DCBM_BUS_ILV_A = 2'h1,
    DCBM_BUS_ILV_B = 2'h2,
    DCBM_BUS_HALF  = 2'h3
  } dcbm_bus_t;

  typedef enum logic [1:0] {
    DCBM_PH_A = 2'h1,
    DCBM_PH_B = 2'h2
  } dcbm_phase_t;

endpackage

// ---- hdl/dcbm_top.sv ----
// Purpose: input clocking, bus routing and sample pairing of a dual DAC
// Assumes: pin inputs synchronous to pclk; pclk is the sample clock
// Notes: fifo and top share this file
`timescale 1ns/1ps
`default_nettype none
`include "dcbm_cfg.svh"

// -----------------------------------------------------------------
// sample fifo
// -----------------------------------------------------------------
module dcbm_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = `DCBM_FIFO_DEPTH,
  parameter int AW = `DCBM_FIFO_AW
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic flush,
  input wire logic single_entry,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [AW:0] level
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] count_ff;
  logic [AW:0] cap;
  logic push;
  logic pop;

  assign cap = single_entry ? (AW+1)'(1) : (AW+1)'(DEPTH);
  assign in_ready = count_ff < cap;
  assign out_valid = count_ff != '0;
  assign out_data = mem[rd_ptr_ff];
  assign level = count_ff;
  assign push = in_valid & in_ready & ~flush;
  assign pop = out_valid & out_ready & ~flush;

  always_ff @(posedge pclk) begin
    if (ce && push) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else if (ce) begin
      if (flush) begin
        wr_ptr_ff <= '0;
        rd_ptr_ff <= '0;
        count_ff <= '0;
      end else begin
        if (push) begin
          wr_ptr_ff <= single_entry ? '0 : wr_ptr_ff + 1'b1;
        end
        if (pop) begin
          rd_ptr_ff <= single_entry ? '0 : rd_ptr_ff + 1'b1;
        end
        count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
      end
    end
  end
endmodule

// -----------------------------------------------------------------
// top
// -----------------------------------------------------------------
// Overview of operation
// - Three control bits pick synchronous dual, plain dual or external clocking.
// - Synchronous dual clocking uses clock alignment and fifo entry zero only.
// - Plain dual clocking runs the fifo as an elastic buffer resynced by sync inputs.
// - External clocking drives the shared pin with a clock at the data rate.
// - Both dual modes take the data-rate clock from the shared pin and its complement.
// - No clock-multiplying mode exists; other bit patterns leave the block idle.
// - Bus select 00 takes channel A from port A and channel B from port B.
// - Bus select 01 or 10 takes one interleaved stream from port A or B and splits it.
// - With the flag select set, a word at the transmit gate rising edge is an A sample.
// - With the flag select clear, the unused port msb marks A by 1 and B by 0.
// - Bus select 11 merges half-rate words from both ports into channel A.
module dcbm_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`DCBM_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic data_rate_clock,
  input wire logic data_rate_clock_complement,
  input wire logic transmit_gate,
  input wire logic sync_in,
  input wire logic [`DCBM_SAMPLE_W-1:0] port_a_samples,
  input wire logic [`DCBM_SAMPLE_W-1:0] port_b_samples,
  output logic shared_clock_pin_out,
  output logic shared_clock_pin_oe,
  output logic [`DCBM_SAMPLE_W-1:0] path_a_data,
  output logic [`DCBM_SAMPLE_W-1:0] path_b_data,
  output logic path_strobe,
  output dcbm_pkg::dcbm_mode_t clock_mode
);
  import dcbm_pkg::*;

  localparam int SW = `DCBM_SAMPLE_W;
  localparam int PW = `DCBM_PER_W;

  function automatic logic [PW-1:0] dcbm_chan_period(
    input logic [1:0] interp
  );
    dcbm_chan_period = (interp >= 2'h2) ? PW'(8) : PW'(2) << interp;
  endfunction

  function automatic logic [PW-1:0] dcbm_word_period(
    input logic [1:0] interp,
    input dcbm_bus_t bus
  );
    logic [PW-1:0] p;
    p = dcbm_chan_period(interp);
    if (bus == DCBM_BUS_ILV_A || bus == DCBM_BUS_ILV_B) begin
      p = p >> 1;
    end else if (bus == DCBM_BUS_HALF) begin
      p = PW'(p << 1);
    end
    dcbm_word_period = (p < `DCBM_PER_MIN) ? `DCBM_PER_MIN : p;
  endfunction

  function automatic dcbm_mode_t dcbm_mode_of(
    input logic [`DCBM_CTRL_W-1:0] c
  );
    logic [2:0] b;
    b = {c[`DCBM_SYNCSEL_BIT], c[`DCBM_CLKOFF_BIT], c[`DCBM_DUALEN_BIT]};
    dcbm_mode_of = (b == 3'h7) ? DCBM_MODE_SYNC
      : (b == 3'h3) ? DCBM_MODE_DUAL
      : (b == 3'h0) ? DCBM_MODE_EXT
      : DCBM_MODE_OFF;
  endfunction

  // -----------------------------------------------------------------
  // apb slave
  // -----------------------------------------------------------------
  logic [`DCBM_CTRL_W-1:0] ctrl_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic ovf_ff;
  logic unf_ff;
  logic [`DCBM_FIFO_AW:0] level;
  logic acc;
  logic done;
  logic hit_ctrl;
  logic hit_stat;
  logic hit_sync;
  logic hit_any;
  logic wr_ctrl;
  logic wr_stat;
  logic sync_req;
  logic [31:0] stat_word;
  logic [31:0] nxt_prdata;

  assign acc = psel & penable;
  assign done = acc & pready_ff;
  assign hit_ctrl = paddr == `DCBM_CTRL_OFS;
  assign hit_stat = paddr == `DCBM_STAT_OFS;
  assign hit_sync = paddr == `DCBM_SYNC_OFS;
  assign hit_any = hit_ctrl | hit_stat | hit_sync;
  assign wr_ctrl = done & pwrite & hit_ctrl;
  assign wr_stat = done & pwrite & hit_stat;
  assign sync_req = sync_in
    | (done & pwrite & hit_sync & pwdata[`DCBM_SYNC_GO_BIT]);
  assign stat_word = {22'h0, unf_ff, ovf_ff,
    level, 4'(clock_mode)};
  assign nxt_prdata = hit_ctrl ? {23'h0, ctrl_ff}
    : hit_stat ? stat_word : 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      prdata_ff <= 32'h0;
      pslverr_ff <= 1'b0;
    end else if (ce) begin
      pready_ff <= acc & ~pready_ff;
      prdata_ff <= (acc & ~pready_ff & ~pwrite) ? nxt_prdata : 32'h0;
      pslverr_ff <= acc & ~pready_ff & ~hit_any;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= `DCBM_CTRL_RST;
    end else if (ce && wr_ctrl) begin
      ctrl_ff <= pwdata[`DCBM_CTRL_W-1:0];
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;

  // -----------------------------------------------------------------
  // clock mode decode
  // -----------------------------------------------------------------
  logic [`DCBM_CTRL_W-1:0] nxt_ctrl;
  logic [1:0] interp;
  logic flag_sel;
  logic run;
  dcbm_bus_t bus;
  dcbm_mode_t mode;
  dcbm_mode_t clock_mode_ff;

  assign nxt_ctrl = wr_ctrl ? pwdata[`DCBM_CTRL_W-1:0] : ctrl_ff;
  assign mode = dcbm_mode_of(ctrl_ff);
  assign bus = dcbm_bus_t'(ctrl_ff[`DCBM_BUS_LO +: 2]);
  assign interp = ctrl_ff[`DCBM_INTERP_LO +: 2];
  assign flag_sel = ctrl_ff[`DCBM_FLAG_BIT];
  assign run = ctrl_ff[`DCBM_EN_BIT] & (mode != DCBM_MODE_OFF);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_mode_ff <= DCBM_MODE_EXT;
    end else if (ce) begin
      clock_mode_ff <= dcbm_mode_of(nxt_ctrl);
    end
  end

  assign clock_mode = clock_mode_ff;

  // -----------------------------------------------------------------
  // word strobe: pin clock or own divider
  // -----------------------------------------------------------------
  logic drc_ff;
  logic drc_level;
  logic drc_rise;
  logic [PW-1:0] div_ff;
  logic [PW-1:0] word_per;
  logic div_wrap;
  logic clk_out_ff;
  logic oe_ff;
  logic strobe;
  logic is_dual_mode;

  assign is_dual_mode = (mode == DCBM_MODE_SYNC) | (mode == DCBM_MODE_DUAL);
  assign drc_level = data_rate_clock & ~data_rate_clock_complement;
  assign drc_rise = drc_level & ~drc_ff;
  assign word_per = dcbm_word_period(interp, bus);
  assign div_wrap = div_ff >= word_per - 1'b1;
  assign strobe = run & (is_dual_mode ? drc_rise
    : div_wrap);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drc_ff <= 1'b0;
      div_ff <= '0;
      clk_out_ff <= 1'b0;
      oe_ff <= 1'b0;
    end else if (ce) begin
      drc_ff <= drc_level;
      div_ff <= (div_wrap | ~run) ? '0 : div_ff + 1'b1;
      clk_out_ff <= run & (mode == DCBM_MODE_EXT)
        & (div_ff < (word_per >> 1));
      oe_ff <= mode == DCBM_MODE_EXT;
    end
  end

  assign shared_clock_pin_out = clk_out_ff;
  assign shared_clock_pin_oe = oe_ff;

  // -----------------------------------------------------------------
  // bus routing and a/b pairing
  // -----------------------------------------------------------------
  dcbm_phase_t phase_ff;
  logic [SW-1:0] held_a_ff;
  logic gate_ff;
  logic ilv;
  logic [SW-1:0] ilv_word;
  logic flag_msb;
  logic word_is_a;
  logic pair_now;
  logic [2*SW-1:0] pair_word;
  logic [2*SW-1:0] stage_ff;
  logic stage_vld_ff;
  logic fifo_in_ready;
  logic push_ok;
  logic ovf_set;

  assign ilv = (bus == DCBM_BUS_ILV_A) | (bus == DCBM_BUS_ILV_B);
  assign ilv_word = (bus == DCBM_BUS_ILV_B) ? port_b_samples
    : port_a_samples;
  assign flag_msb = (bus == DCBM_BUS_ILV_B) ? port_a_samples[SW-1]
    : port_b_samples[SW-1];
  assign word_is_a = flag_sel
    ? ((transmit_gate & ~gate_ff) | (phase_ff == DCBM_PH_A))
    : flag_msb;
  assign pair_now = strobe & (~ilv
    | (~word_is_a & (phase_ff == DCBM_PH_B)));
  assign pair_word = ilv ? {held_a_ff, ilv_word}
    : {port_a_samples, port_b_samples};
  assign push_ok = ~stage_vld_ff | fifo_in_ready;
  assign ovf_set = pair_now & ~push_ok;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_ff <= DCBM_PH_A;
      held_a_ff <= '0;
      gate_ff <= 1'b0;
    end else if (ce) begin
      if (strobe) begin
        gate_ff <= transmit_gate;
      end
      if (!run || !ilv) begin
        phase_ff <= DCBM_PH_A;
      end else if (strobe) begin
        unique case (phase_ff)
          DCBM_PH_A: begin
            if (word_is_a) begin
              held_a_ff <= ilv_word;
              phase_ff <= DCBM_PH_B;
            end
          end
          DCBM_PH_B: begin
            if (word_is_a) begin
              held_a_ff <= ilv_word;
            end else begin
              phase_ff <= DCBM_PH_A;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage_ff <= '0;
      stage_vld_ff <= 1'b0;
    end else if (ce) begin
      if (!run) begin
        stage_vld_ff <= 1'b0;
      end else if (pair_now && push_ok) begin
        stage_ff <= pair_word;
        stage_vld_ff <= 1'b1;
      end else if (fifo_in_ready) begin
        stage_vld_ff <= 1'b0;
      end
    end
  end

  // -----------------------------------------------------------------
  // fifo and sample-rate read side
  // -----------------------------------------------------------------
  logic fifo_out_valid;
  logic [2*SW-1:0] fifo_out_data;
  logic pop;
  logic tick;
  logic [PW-1:0] rd_cnt_ff;
  logic rd_wrap;
  logic half_sel_ff;
  logic unf_set;
  logic is_half;

  assign is_half = bus == DCBM_BUS_HALF;
  assign rd_wrap = rd_cnt_ff >= dcbm_chan_period(interp) - 1'b1;
  assign tick = run & ((mode == DCBM_MODE_SYNC) ? fifo_out_valid
    : rd_wrap);
  assign pop = tick & (~is_half | half_sel_ff);
  assign unf_set = tick & ~fifo_out_valid;

  dcbm_fifo #(
    .WIDTH(2*SW),
    .DEPTH(`DCBM_FIFO_DEPTH),
    .AW(`DCBM_FIFO_AW)
  ) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .flush(~run | sync_req),
    .single_entry(mode == DCBM_MODE_SYNC),
    .in_valid(stage_vld_ff),
    .in_ready(fifo_in_ready),
    .in_data(stage_ff),
    .out_valid(fifo_out_valid),
    .out_ready(pop),
    .out_data(fifo_out_data),
    .level(level)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_cnt_ff <= '0;
      half_sel_ff <= 1'b0;
      path_a_data <= '0;
      path_b_data <= '0;
      path_strobe <= 1'b0;
      ovf_ff <= 1'b0;
      unf_ff <= 1'b0;
    end else if (ce) begin
      rd_cnt_ff <= (rd_wrap | ~run | sync_req) ? '0
        : rd_cnt_ff + 1'b1;
      if (!run || sync_req || !is_half) begin
        half_sel_ff <= 1'b0;
      end else if (tick && fifo_out_valid) begin
        half_sel_ff <= ~half_sel_ff;
      end
      path_strobe <= tick & fifo_out_valid;
      if (tick && fifo_out_valid) begin
        if (is_half) begin
          path_a_data <= half_sel_ff ? fifo_out_data[SW-1:0]
            : fifo_out_data[2*SW-1:SW];
          path_b_data <= '0;
        end else begin
          path_a_data <= fifo_out_data[2*SW-1:SW];
          path_b_data <= fifo_out_data[SW-1:0];
        end
      end
      ovf_ff <= ovf_set | (ovf_ff & ~(wr_stat & pwdata[`DCBM_OVF_BIT]));
      unf_ff <= unf_set | (unf_ff & ~(wr_stat & pwdata[`DCBM_UNF_BIT]));
    end
  end
endmodule

`default_nettype wire

// ---- tb/dcbm_src_model.sv ----
// Purpose: data source feeding the input block
// Assumes: words launched right after pclk rising edges
// Notes: released lines fall to their pull-down level
`timescale 1ns/1ps
`default_nettype none
module dcbm_src_model (
  input wire logic pclk,
  output logic data_rate_clock,
  output logic data_rate_clock_complement,
  output logic transmit_gate,
  output logic [15:0] port_a_samples,
  output logic [15:0] port_b_samples
);
  // -----------------------------------------------------------------
  // word launch
  // -----------------------------------------------------------------
  initial begin
    data_rate_clock = 1'b0;
    data_rate_clock_complement = 1'b1;
    rest();
  end
  task automatic send(input logic [15:0] a, input logic [15:0] b,
      input logic g, input int w);
    data_rate_clock <= 1'b1;
    data_rate_clock_complement <= 1'b0;
    port_a_samples <= a;
    port_b_samples <= b;
    transmit_gate <= g;
    repeat (w / 2) @(posedge pclk);
    data_rate_clock <= 1'b0;
    data_rate_clock_complement <= 1'b1;
    repeat (w - w / 2) @(posedge pclk);
  endtask
  task automatic rest();
    port_a_samples <= 16'h0000;
    port_b_samples <= 16'h0000;
    transmit_gate <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- tb/dcbm_top_asserts.sv ----
// Purpose: port checks for the input block
// Assumes: ce held high; ctrl mirrored from apb writes
// Notes: pin and strobe checks wait for the settings to settle, except pair_pulse_a
`timescale 1ns/1ps
`default_nettype none
`include "dcbm_cfg.svh"
module dcbm_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`DCBM_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic data_rate_clock,
  input wire logic data_rate_clock_complement,
  input wire logic sync_in,
  input wire logic shared_clock_pin_out,
  input wire logic shared_clock_pin_oe,
  input wire logic [`DCBM_SAMPLE_W-1:0] path_b_data,
  input wire logic path_strobe,
  input wire dcbm_pkg::dcbm_mode_t clock_mode
);
  import dcbm_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // -----------------------------------------------------------------
  // ctrl mirror and pin counters
  // -----------------------------------------------------------------
  logic [8:0] ctrl_ff;
  logic [5:0] age_ff;
  logic [4:0] per_ff;
  logic [3:0] hi_ff;
  logic pin_q_ff;
  logic lvl_q_ff;
  wire wr_ctrl = psel && penable && pready && pwrite && !pslverr &&
    paddr == `DCBM_CTRL_OFS;
  wire lvl = data_rate_clock && !data_rate_clock_complement;
  wire en_ok = ctrl_ff[`DCBM_EN_BIT] && age_ff >= 6'h18;
  wire [4:0] chan_p = ctrl_ff[7:6] == 2'h0 ? 5'h02 :
    ctrl_ff[7:6] == 2'h1 ? 5'h04 : 5'h08;
  wire [4:0] word_p = ctrl_ff[4:3] == 2'h0 ? chan_p :
    ctrl_ff[4:3] == 2'h3 ? {chan_p[3:0], 1'b0} :
    chan_p == 5'h02 ? chan_p : {1'b0, chan_p[4:1]};
  wire ext_on = clock_mode == DCBM_MODE_EXT && en_ok;
  function automatic dcbm_mode_t dec(input logic [2:0] b);
    return b == 3'h7 ? DCBM_MODE_SYNC : b == 3'h6 ? DCBM_MODE_DUAL :
      b == 3'h0 ? DCBM_MODE_EXT : DCBM_MODE_OFF;
  endfunction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= 9'h000;
      age_ff <= 6'h00;
      per_ff <= 5'h00;
      hi_ff <= 4'h0;
      pin_q_ff <= 1'b0;
      lvl_q_ff <= 1'b0;
    end else begin
      ctrl_ff <= wr_ctrl ? pwdata[8:0] : ctrl_ff;
      age_ff <= wr_ctrl ? 6'h00 : age_ff + {5'h00, age_ff != 6'h3f};
      per_ff <= shared_clock_pin_out && !pin_q_ff ? 5'h01 : per_ff + 5'h01;
      hi_ff <= shared_clock_pin_out ? hi_ff + 4'h1 : 4'h0;
      pin_q_ff <= shared_clock_pin_out;
      lvl_q_ff <= lvl;
    end
  end
  mode_decode_a: assert property (wr_ctrl |=>
    clock_mode == dec($past(pwdata[2:0]))) else $error("bad clock mode");
  pin_dir_a: assert property (age_ff >= 6'h03 |->
    shared_clock_pin_oe == (clock_mode == DCBM_MODE_EXT))
    else $error("bad pin direction");
  pin_quiet_a: assert property (age_ff >= 6'h03 &&
    clock_mode != DCBM_MODE_EXT |-> !shared_clock_pin_out)
    else $error("pin toggles as input");
  pin_period_a: assert property (ext_on && shared_clock_pin_out &&
    !pin_q_ff |-> per_ff == word_p) else $error("bad clock period");
  pin_high_a: assert property (ext_on && !shared_clock_pin_out &&
    pin_q_ff |-> {1'b0, hi_ff} == {1'b0, word_p[4:1]})
    else $error("bad clock high time");
  idle_off_a: assert property (clock_mode == DCBM_MODE_OFF &&
    age_ff >= 6'h18 |-> !path_strobe) else $error("output while off");
  sync_lat_a: assert property (clock_mode == DCBM_MODE_SYNC &&
    en_ok && !sync_in && lvl && !lvl_q_ff |-> ##3 path_strobe)
    else $error("sync pair late");
  half_b_a: assert property (path_strobe && ctrl_ff[4:3] == 2'h3 &&
    en_ok |-> path_b_data == 16'h0000) else $error("half rate b set");
  pair_pulse_a: assert property (path_strobe |=> !path_strobe)
    else $error("strobe too long");
  apb_wait_a: assert property ($rose(penable) && psel |=>
    pready && psel && penable) else $error("apb answer late");
  apb_err_a: assert property (pready && paddr > `DCBM_SYNC_OFS |->
    pslverr && prdata == 32'h0) else $error("unmapped not refused");
  cover property (clock_mode == DCBM_MODE_SYNC && path_strobe);
  cover property (ext_on && shared_clock_pin_out && !pin_q_ff);
  cover property (pready && pslverr);
endmodule
bind dcbm_top dcbm_chk i_dcbm_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .data_rate_clock,
  .data_rate_clock_complement, .sync_in, .shared_clock_pin_out,
  .shared_clock_pin_oe, .path_b_data, .path_strobe, .clock_mode);
`default_nettype wire

// ---- tb/testbench.sv ----
// Purpose: self-checking bench for the input block
// Assumes: ce held high; model is the data source
// Notes: driver queues pairs, monitor matches them
`timescale 1ns/1ps
`default_nettype none
`include "dcbm_cfg.svh"
module testbench;
  import dcbm_pkg::*;
  logic pclk, presetn, ce, psel, penable, pwrite, sync_in, chk_en;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata_v, want_v;
  logic pready, pslverr, err_v, src_clk, pin_out, pin_oe, drc_c;
  logic transmit_gate, path_strobe;
  logic [15:0] port_a_samples, port_b_samples, path_a_data, path_b_data;
  dcbm_mode_t clock_mode;
  logic [31:0] exp_q[$];
  logic [31:0] ext_cfg[4] = '{32'h100, 32'h140, 32'h188, 32'h118};
  int fail_count, n_tests, seed;
  wire data_rate_clock = pin_oe ? pin_out : src_clk;
  // -----------------------------------------------------------------
  // instances, clock, tasks
  // -----------------------------------------------------------------
  dcbm_top i_dcbm_top (.pclk, .presetn, .ce, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .data_rate_clock,
    .data_rate_clock_complement(drc_c), .transmit_gate, .sync_in,
    .port_a_samples, .port_b_samples, .shared_clock_pin_out(pin_out),
    .shared_clock_pin_oe(pin_oe), .path_a_data, .path_b_data,
    .path_strobe, .clock_mode);
  dcbm_src_model i_dcbm_src_model (.pclk, .data_rate_clock(src_clk),
    .data_rate_clock_complement(drc_c), .transmit_gate, .port_a_samples,
    .port_b_samples);
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_tests++;
    if (seen !== want) begin
      fail_count++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdata_v = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      check(32'h0, 32'h1);
      summarize();
    end
    @(posedge pclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] want,
      input logic [31:0] mask);
    apb(1'b0, a, 32'h0);
    check(rdata_v & mask, want);
  endtask
  task automatic pairs(input int n, input int w, input int kind);
    logic [15:0] a;
    logic [15:0] b;
    for (int i = 0; i < n; i++) begin
      a = 16'($random(seed));
      b = 16'($random(seed));
      exp_q.push_back(kind == 3 ? {a, 16'h0000} : {a, b});
      if (kind == 3) begin
        exp_q.push_back({b, 16'h0000});
      end
      if (kind == 0 || kind == 3) begin
        i_dcbm_src_model.send(a, b, 1'b0, w);
      end else if (kind == 1) begin
        i_dcbm_src_model.send(a, 16'h8000, 1'b0, w);
        i_dcbm_src_model.send(b, 16'h0000, 1'b0, w);
      end else begin
        i_dcbm_src_model.send(16'h0000, a, 1'b1, w);
        i_dcbm_src_model.send(16'h0000, b, 1'b1, w);
      end
    end
    i_dcbm_src_model.rest();
  endtask
  task automatic drain(input string name);
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 500) begin
      @(posedge pclk);
      n++;
    end
    check(exp_q.size(), 32'h0);
    if (exp_q.size() != 0) begin
      summarize();
    end
    repeat (8) @(posedge pclk);
    $display("test %s done", name);
  endtask
  always @(posedge pclk) begin
    if (chk_en && path_strobe === 1'b1) begin
      want_v = exp_q.size() > 0 ? exp_q.pop_front() : 32'hxxxxxxxx;
      check({path_a_data, path_b_data}, want_v);
    end
  end
  // -----------------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------------
  initial begin
    seed = 97634;
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    sync_in = 1'b0;
    chk_en = 1'b1;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`DCBM_STAT_OFS, 32'h008, 32'h00f);
    apb(1'b1, 12'h00c, 32'h1ff);
    check({31'h0, err_v}, 32'h1);
    rd(`DCBM_CTRL_OFS, 32'h000, 32'h1ff);
    apb(1'b1, `DCBM_CTRL_OFS, 32'h107);
    pairs(16, 2, 0);
    drain("sync_dual_bus");
    apb(1'b1, `DCBM_CTRL_OFS, 32'h14e);
    sync_in <= 1'b1;
    @(posedge pclk);
    sync_in <= 1'b0;
    // a lone b word before any a word is dropped
    i_dcbm_src_model.send(16'h1234, 16'h0000, 1'b0, 2);
    pairs(8, 2, 1);
    drain("interleaved_msb");
    apb(1'b1, `DCBM_CTRL_OFS, 32'h176);
    pairs(8, 2, 2);
    drain("interleaved_gate");
    apb(1'b1, `DCBM_CTRL_OFS, 32'h11e);
    pairs(8, 4, 3);
    drain("half_rate");
    chk_en <= 1'b0;
    foreach (ext_cfg[i]) begin
      apb(1'b1, `DCBM_CTRL_OFS, ext_cfg[i]);
      repeat (40) @(posedge pclk);
      rd(`DCBM_STAT_OFS, 32'h008, 32'h00f);
    end
    apb(1'b1, `DCBM_CTRL_OFS, 32'h101);
    repeat (30) @(posedge pclk);
    rd(`DCBM_STAT_OFS, 32'h001, 32'h00f);
    $display("test clock_modes done");
    apb(1'b1, `DCBM_CTRL_OFS, 32'h186);
    apb(1'b1, `DCBM_STAT_OFS, 32'h300);
    apb(1'b1, `DCBM_SYNC_OFS, 32'h1);
    pairs(20, 2, 0);
    exp_q.delete();
    rd(`DCBM_STAT_OFS, 32'h100, 32'h100);
    repeat (150) @(posedge pclk);
    rd(`DCBM_STAT_OFS, 32'h304, 32'h3ff);
    apb(1'b1, `DCBM_STAT_OFS, 32'h300);
    rd(`DCBM_STAT_OFS, 32'h000, 32'h100);
    $display("test elastic_fifo done");
    summarize();
  end
endmodule
`default_nettype wire
